// [core/ppg_port_group.sv]
// nine-group parallel I/O block with its software register port
`timescale 1ns/1ps
`include "ppg_defines.svh"

// Summary of operation
// RQ1: 111 lines in nine software-controlled groups
// RQ2: group three lacks line fourteen
// RQ3: group five sixteen bits, input only
// RQ4: every pin sampled each clock
// RQ5: input pin: write latch, read pin
// RQ6: input pin: modify pin value into latch
// RQ7: output pin: drives latch, reads latch
// RQ8: output pin: modify latch value, drives pin
// RQ9: open-drain select on groups 2,3,4,6,7,8
// RQ10: one threshold bit per byte (group 6 has none here)
// RQ11: direction and drive ignore threshold choice
// RQ12: each line has one alternate function
// RQ13: alternate output only when direction outputs
// RQ14: drive is latch AND alternate, PWM bypasses
// RQ15: software keeps latch one for alternates
// RQ16: directions reset to input
// RQ17: output pin feeds latch to alternate input
// RQ18: software sets direction before alternate enable
// RQ19: hardware switches direction on automatic lines
// RQ20: unclaimed lines stay general purpose
// RQ21: open-drain and thresholds reset cleared
module ppg_port_group (
    input  wire logic                                clock_in,
    input  wire logic                                rst_in,
    input  wire logic [7:0]                          addr_in,
    input  wire logic [15:0]                         wdata_in,
    input  wire logic                                wr_in,
    input  wire logic                                rd_in,
    output logic [15:0]                              rdata_out,
    input  wire ppg_pkg::ppg_port_word_t             pins_in,
    input  wire ppg_pkg::ppg_alt_ctrl_t [8:0]        alt_in,
    output ppg_pkg::ppg_pad_drive_t [8:0]            pads_out,
    output ppg_pkg::ppg_port_word_t                  alt_data_out,
    output ppg_pkg::ppg_thresh_t                     thresh_cmos_out
);
    import ppg_pkg::*;

    // ============================================================
    // constants
    localparam logic [143:0] IMPL_MASKS = `PPG_IMPL_MASKS;  // implemented lines
    localparam logic [143:0] OUT_MASKS  = `PPG_OUT_MASKS;   // lines with a driver
    localparam logic [143:0] ODS_MASKS  = `PPG_ODS_MASKS;   // lines with open-drain select

    // ============================================================
    // state
    ppg_port_word_t           data_latch;       // output latches
    ppg_port_word_t           dir;              // pin_direction_bit per line, 1 = output
    ppg_port_word_t           open_drain_select; // 1 = open drain
    ppg_port_word_t           sample;           // input latches
    logic [`PPG_ITS_W-1:0]    input_threshold_select;     // cmos select, groups 0..3
    logic [`PPG_XITS_W-1:0]   ext_input_threshold_select; // cmos select, groups 4,5,7,8

    // ============================================================
    // decode of the register port
    wire its_wr  = wr_in && (addr_in == `PPG_ITS_ADDR);   // threshold register write
    wire xits_wr = wr_in && (addr_in == `PPG_XITS_ADDR);  // extended threshold write
    wire its_rd  = addr_in == `PPG_ITS_ADDR;
    wire xits_rd = addr_in == `PPG_XITS_ADDR;

    // read contributions chained through the groups
    logic [9:0][15:0] rd_chain;
    assign rd_chain[0] = 16'h0000;

    // ============================================================
    // per-group logic
    genvar p;
    generate
        for (p = 0; p < PPG_PORTS; p++) begin : g_port
            // masks of this group; absent lines never store nor drive [RQ1] [RQ2] [RQ3]
            wire [15:0] impl_m = IMPL_MASKS[p*16 +: 16];
            wire [15:0] out_m  = OUT_MASKS[p*16 +: 16];
            wire [15:0] ods_m  = ODS_MASKS[p*16 +: 16];

            // register hits of this group
            wire hit_data = addr_in == (`PPG_DATA_BASE + 8'(p));
            wire hit_dir  = addr_in == (`PPG_DIR_BASE + 8'(p));
            wire hit_ods  = addr_in == (`PPG_ODS_BASE + 8'(p));
            wire hit_set  = addr_in == (`PPG_SET_BASE + 8'(p));
            wire hit_clr  = addr_in == (`PPG_CLR_BASE + 8'(p));
            wire hit_tgl  = addr_in == (`PPG_TGL_BASE + 8'(p));

            // port read value: latch for outputs, sampled pin for inputs [RQ5] [RQ7]
            wire [15:0] read_val = (dir[p] & data_latch[p]) | (~dir[p] & sample[p]);

            // read-modify-write takes the read value above, so inputs fold the pin
            // level and outputs the latch level back into the latch [RQ6] [RQ8]
            wire [15:0] rmw_set = read_val | wdata_in;
            wire [15:0] rmw_clr = read_val & ~wdata_in;
            wire [15:0] rmw_tgl = read_val ^ wdata_in;

            // every write lands in the latch whatever the direction [RQ5] [RQ7]
            wire [15:0] next_latch =
                (wr_in && hit_data) ? (wdata_in & impl_m) :
                (wr_in && hit_set)  ? (rmw_set & impl_m) :
                (wr_in && hit_clr)  ? (rmw_clr & impl_m) :
                (wr_in && hit_tgl)  ? (rmw_tgl & impl_m) :
                data_latch[p];

            // direction and open-drain stores, kept per line [RQ9] [RQ11]
            wire [15:0] next_dir = (wr_in && hit_dir) ? (wdata_in & out_m) : dir[p];
            wire [15:0] next_ods = (wr_in && hit_ods) ? (wdata_in & ods_m) : open_drain_select[p];

            // effective direction: automatic lines follow the peripheral [RQ19]
            wire [15:0] eff_dir = ((alt_in[p].auto_dir_en & alt_in[p].auto_dir) |
                                   (~alt_in[p].auto_dir_en & dir[p])) & out_m;

            // drive value: latch alone, latch AND alternate, or raw pwm [RQ14] [RQ12] [RQ20]
            wire [15:0] alt_gated = data_latch[p] & alt_in[p].data;
            wire [15:0] alt_val   = (alt_in[p].pwm_bypass & alt_in[p].data) |
                                    (~alt_in[p].pwm_bypass & alt_gated);
            wire [15:0] drv_val   = (alt_in[p].enable & alt_val) |
                                    (~alt_in[p].enable & data_latch[p]);

            // pad enable: only with output direction, and open drain only pulls low [RQ13] [RQ9]
            wire [15:0] next_oe_n  = ~(eff_dir & (~open_drain_select[p] | ~drv_val));
            wire [15:0] next_level = drv_val & ~open_drain_select[p] & eff_dir;

            // alternate input sees the latch when the line drives, else the pin [RQ17]
            wire [15:0] next_alt = ((eff_dir & data_latch[p]) | (~eff_dir & sample[p])) & impl_m;

            // read contribution of this group
            wire [15:0] rd_part = ({16{hit_data}} & read_val) |
                                  ({16{hit_dir}}  & dir[p]) |
                                  ({16{hit_ods}}  & open_drain_select[p]);
            assign rd_chain[p+1] = rd_chain[p] | rd_part;

            // latches, directions and pads of this group
            always_ff @(posedge clock_in) begin
                if (rst_in) begin
                    data_latch[p]        <= `PPG_RST_WORD;
                    dir[p]               <= `PPG_RST_DIR;      // all inputs [RQ16]
                    open_drain_select[p] <= `PPG_RST_ODS;      // push-pull [RQ21]
                    sample[p]            <= `PPG_RST_WORD;
                    pads_out[p].level    <= `PPG_RST_WORD;
                    pads_out[p].oe_n     <= `PPG_RST_OE_N;
                    alt_data_out[p]      <= `PPG_RST_WORD;
                end else begin
                    data_latch[p]        <= next_latch;
                    dir[p]               <= next_dir;
                    open_drain_select[p] <= next_ods;
                    sample[p]            <= pins_in[p] & impl_m; // every clock, any direction [RQ4]
                    pads_out[p].level    <= next_level;
                    pads_out[p].oe_n     <= next_oe_n;
                    alt_data_out[p]      <= next_alt;
                end
            end
        end
    endgenerate

    // ============================================================
    // threshold selects, one bit per byte except group 6, which has none [RQ10]
    wire [`PPG_ITS_W-1:0]  next_its  = its_wr  ? wdata_in[`PPG_ITS_W-1:0]  : input_threshold_select;
    wire [`PPG_XITS_W-1:0] next_xits = xits_wr ? wdata_in[`PPG_XITS_W-1:0] : ext_input_threshold_select;

    // byte map: groups 0..3 take two bits each, 4/7/8 one, 5 two, 6 has none
    ppg_thresh_t next_thresh;
    assign next_thresh[0] = input_threshold_select[1:0];
    assign next_thresh[1] = input_threshold_select[3:2];
    assign next_thresh[2] = input_threshold_select[5:4];
    assign next_thresh[3] = input_threshold_select[7:6];
    assign next_thresh[4] = {2{ext_input_threshold_select[`PPG_XITS_P4]}};
    assign next_thresh[5] = {ext_input_threshold_select[`PPG_XITS_P5H], ext_input_threshold_select[`PPG_XITS_P5L]};
    assign next_thresh[6] = 2'h0;
    assign next_thresh[7] = {2{ext_input_threshold_select[`PPG_XITS_P7]}};
    assign next_thresh[8] = {2{ext_input_threshold_select[`PPG_XITS_P8]}};

    // ============================================================
    // read data: unmapped addresses answer zero
    wire [15:0] next_rdata = rd_chain[PPG_PORTS] |
                             (its_rd  ? {8'h00, input_threshold_select} : 16'h0000) |
                             (xits_rd ? {11'h000, ext_input_threshold_select} : 16'h0000);

    // threshold registers and read port; threshold never touches direction or drive [RQ11]
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            input_threshold_select     <= `PPG_RST_ITS;   // ttl [RQ21]
            ext_input_threshold_select <= `PPG_RST_XITS;  // ttl [RQ21]
            thresh_cmos_out            <= '0;
            rdata_out                  <= `PPG_RST_WORD;
        end else begin
            input_threshold_select     <= next_its;
            ext_input_threshold_select <= next_xits;
            thresh_cmos_out            <= next_thresh;
            // held at zero outside the cycle after a read
            rdata_out                  <= rd_in ? next_rdata : 16'h0000;
        end
    end

endmodule

// [include/ppg_defines.svh]
// register offsets, field layouts, masks and reset values of the parallel port group
`ifndef PPG_DEFINES_SVH
`define PPG_DEFINES_SVH

// ============================================================
// register offsets (word index on the 8-bit register address)
`define PPG_DATA_BASE    8'h00
`define PPG_DIR_BASE     8'h10
`define PPG_ODS_BASE     8'h20
`define PPG_SET_BASE     8'h30
`define PPG_CLR_BASE     8'h40
`define PPG_TGL_BASE     8'h50
`define PPG_ITS_ADDR     8'h60
`define PPG_XITS_ADDR    8'h61

// ============================================================
// per-port bit masks, port 8 in the top word, port 0 in the bottom word
`define PPG_IMPL_MASKS   144'h00ff_00ff_00ff_ffff_00ff_bfff_ffff_ffff_ffff
`define PPG_OUT_MASKS    144'h00ff_00ff_00ff_0000_00ff_bfff_ffff_ffff_ffff
`define PPG_ODS_MASKS    144'h00ff_00ff_00ff_0000_00ff_bfff_ffff_0000_0000

// ============================================================
// threshold select fields
`define PPG_ITS_W        8
`define PPG_XITS_W       5
`define PPG_XITS_P4      0
`define PPG_XITS_P5L     1
`define PPG_XITS_P5H     2
`define PPG_XITS_P7      3
`define PPG_XITS_P8      4

// ============================================================
// reset values
`define PPG_RST_WORD     16'h0000
`define PPG_RST_DIR      16'h0000
`define PPG_RST_ODS      16'h0000
`define PPG_RST_ITS      8'h00
`define PPG_RST_XITS     5'h00
`define PPG_RST_OE_N     16'hffff

`endif

// [include/ppg_pkg.sv]
// types shared by the parallel port group and its bench
package ppg_pkg;

    // ============================================================
    // sizes
    localparam int PPG_PORTS = 9;

    typedef logic [15:0]      ppg_word_t;
    typedef logic [8:0][15:0] ppg_port_word_t;
    typedef logic [8:0][1:0]  ppg_thresh_t;

    // ============================================================
    // per-port alternate function controls from the peripherals
    typedef struct packed {
        logic [15:0] enable;      // line claimed by its alternate function
        logic [15:0] data;        // alternate output data
        logic [15:0] pwm_bypass;  // alternate output skips the latch gating
        logic [15:0] auto_dir_en; // hardware owns the direction
        logic [15:0] auto_dir;    // hardware direction, 1 = drive
    } ppg_alt_ctrl_t;

    // ============================================================
    // per-port pad drive
    typedef struct packed {
        logic [15:0] level;       // value driven while enabled
        logic [15:0] oe_n;        // low while the pad is driven
    } ppg_pad_drive_t;

endpackage

// [verification/ppg_port_group_properties.sv]
// concurrent checks on the ports of the parallel port group
`timescale 1ns/1ps
module ppg_port_group_properties
    import ppg_pkg::*;
(
    input wire logic                         clock_in,
    input wire logic                         rst_in,
    input wire logic [7:0]                   addr_in,
    input wire logic [15:0]                  wdata_in,
    input wire logic                         wr_in,
    input wire logic                         rd_in,
    input wire logic [15:0]                  rdata_out,
    input wire ppg_pkg::ppg_port_word_t      pins_in,
    input wire ppg_pkg::ppg_alt_ctrl_t [8:0] alt_in,
    input wire ppg_pkg::ppg_pad_drive_t [8:0] pads_out,
    input wire ppg_pkg::ppg_port_word_t      alt_data_out,
    input wire ppg_pkg::ppg_thresh_t         thresh_cmos_out
);
    // ============================================================
    // one clock domain, so clock and reset are given once
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);

    a_rdata_only_read: assert property (rdata_out != 16'h0 |-> $past(rd_in))
        else $error("read data outside a read answer");
    a_group5_never_driven: assert property (pads_out[5].oe_n == 16'hffff)
        else $error("input-only group driven");
    a_line_fourteen_absent: assert property (pads_out[3].oe_n[14])
        else $error("absent line driven");
    a_dir_reset_input: assert property ($fell(rst_in) |-> pads_out[0].oe_n == 16'hffff
        && pads_out[2].oe_n == 16'hffff) else $error("pad driven after reset");
    a_thresh_reset_clear: assert property ($fell(rst_in) |-> thresh_cmos_out == '0)
        else $error("threshold not cleared by reset");
    a_dir_write_drives: assert property (wr_in && addr_in == 8'h10 && alt_in[0].auto_dir_en == 16'h0
        ##1 alt_in[0].auto_dir_en == 16'h0 |=> pads_out[0].oe_n == ~$past(wdata_in, 2))
        else $error("direction write did not reach the pads");
    a_pwm_bypass_auto: assert property (alt_in[0].enable == 16'hffff && alt_in[0].pwm_bypass == 16'hffff
        && alt_in[0].auto_dir_en == 16'hffff && alt_in[0].auto_dir == 16'hffff
        |=> pads_out[0].oe_n == 16'h0 && pads_out[0].level == $past(alt_in[0].data))
        else $error("bypassed alternate data not driven");
    a_auto_dir_float: assert property (alt_in[0].auto_dir_en == 16'hffff && alt_in[0].auto_dir == 16'h0
        |=> pads_out[0].oe_n == 16'hffff) else $error("automatic input line driven");
    a_group5_read_pin: assert property (rd_in && addr_in == 8'h05 && !$past(rst_in)
        |=> rdata_out == $past(pins_in[5], 2)) else $error("input group read wrong");
    a_thresh_write: assert property (wr_in && addr_in == 8'h60
        |-> ##2 thresh_cmos_out[2] == $past(wdata_in[5:4], 2)) else $error("threshold bits wrong");
endmodule

bind ppg_port_group ppg_port_group_properties chk_inst (.clock_in(clock_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .pins_in(pins_in),
    .alt_in(alt_in), .pads_out(pads_out), .alt_data_out(alt_data_out), .thresh_cmos_out(thresh_cmos_out));

// [verification/ppg_pad_model.sv]
// pads with external pull-ups and drivers around the port group
`timescale 1ns/1ps
module ppg_pad_model
    import ppg_pkg::*;
(
    input  wire ppg_pkg::ppg_pad_drive_t [8:0] pads_in,
    input  wire ppg_pkg::ppg_port_word_t       ext_in,   // external level where the pad is released
    output ppg_pkg::ppg_port_word_t            pins_out
);
    // ============================================================
    // a released pad shows the outside level, never its last driven value
    for (genvar p = 0; p < 9; p++) begin : g_pad
        assign pins_out[p] = (~pads_in[p].oe_n & pads_in[p].level) | (pads_in[p].oe_n & ext_in[p]);
    end
endmodule

// [verification/ppg_port_group_bench.sv]
// self-checking bench of the parallel port group
`timescale 1ns/1ps
`include "ppg_defines.svh"
module ppg_port_group_bench;
    import ppg_pkg::*;
    logic               clock_in = 1'b0, rst_in = 1'b1, wr_s = 1'b0, rd_s = 1'b0;
    logic [7:0]         addr = 8'h00;
    logic [15:0]        wdata = 16'h0000, rdata, d, v, e, w, r, a;
    logic [143:0]       om = `PPG_OUT_MASKS, odm = `PPG_ODS_MASKS;
    ppg_port_word_t     pins, alt_data, ext = '1;
    ppg_alt_ctrl_t [8:0] alt = '0;
    ppg_pad_drive_t [8:0] pads;
    ppg_thresh_t        thr;
    int                 failures = 0, compares = 0, seed = 32'h6fd1606e, op;

    always #25 clock_in = ~clock_in; // 20 MHz

    ppg_port_group ppg_port_group_inst (.clock_in(clock_in), .rst_in(rst_in), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr_s), .rd_in(rd_s), .rdata_out(rdata), .pins_in(pins), .alt_in(alt), .pads_out(pads),
        .alt_data_out(alt_data), .thresh_cmos_out(thr));
    ppg_pad_model ppg_pad_model_inst (.pads_in(pads), .ext_in(ext), .pins_out(pins));

    // ============================================================
    // comparison, bus cycles and expectation helpers
    task chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] ad, input logic [15:0] dt);
        @(posedge clock_in);
        addr  <= ad;
        wdata <= dt;
        wr_s  <= 1'b1;
        @(posedge clock_in);
        wr_s <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task rd(input logic [7:0] ad, input logic [15:0] exp);
        @(posedge clock_in);
        addr <= ad;
        rd_s <= 1'b1;
        @(posedge clock_in);
        rd_s <= 1'b0;
        @(negedge clock_in);
        chk(rdata, exp);
    endtask
    // pads lag writes by two edges and samples by one more
    task settle;
        repeat (4) @(posedge clock_in);
        @(negedge clock_in);
    endtask
    function logic [15:0] rmw(int k, logic [15:0] x, logic [15:0] y);
        return (k == 0) ? (x | y) : (k == 1) ? (x & ~y) : (x ^ y);
    endfunction
    task complete_run;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        repeat (50000) @(posedge clock_in);
        failures++;
        complete_run();
    end

    // ============================================================
    // main sequence
    initial begin
        repeat (10) @(posedge clock_in);
        rst_in <= 1'b0;
        for (int p = 0; p < 9; p++) begin
            rd(8'h10 + p[7:0], 16'h0);
            rd(8'h20 + p[7:0], 16'h0);
        end
        rd(8'h60, 16'h0);
        $display("test reset done");
        // every group: implemented driver and open-drain bits
        for (int p = 0; p < 9; p++) begin
            wr(8'h10 + p[7:0], 16'hffff);
            rd(8'h10 + p[7:0], om[16*p+:16]);
            wr(8'h20 + p[7:0], 16'hffff);
            rd(8'h20 + p[7:0], odm[16*p+:16]);
            wr(8'h20 + p[7:0], 16'h0);
            wr(8'h10 + p[7:0], 16'h0);
        end
        $display("test masks done");
        // random mixed directions with read-modify-write on group 0
        repeat (20) begin
            d = 16'($random(seed));
            v = 16'($random(seed));
            e = 16'($random(seed));
            w = 16'($random(seed));
            op = {$random(seed)} % 3;
            // pins change only just after a rising edge, like every other input
            @(posedge clock_in);
            ext[0] <= e;
            wr(8'h10, d);
            wr(8'h00, v);
            settle();
            r = (d & v) | (~d & e);
            chk(pins[0], r);
            chk(alt_data[0], r);
            rd(8'h00, r);
            wr(8'h30 + 8'h10 * op[7:0], w);
            wr(8'h10, 16'hffff);
            settle();
            rd(8'h00, rmw(op, r, w));
        end
        $display("test gpio done");
        w = 16'($random(seed));
        wr(8'h60, w);
        wr(8'h61, w);
        settle();
        chk(16'(thr[0]), 16'(w[1:0]));
        chk(16'(thr[5]), 16'(w[2:1]));
        chk(16'(thr[8]), 16'({2{w[4]}}));
        rd(8'h10, 16'hffff);
        $display("test threshold done");
        // open drain on group 2 only pulls low; released lines show the outside level
        v = 16'($random(seed));
        e = 16'($random(seed));
        @(posedge clock_in);
        ext[2] <= e;
        wr(8'h22, 16'hffff);
        wr(8'h12, 16'hffff);
        wr(8'h02, v);
        settle();
        chk(pins[2], v & e);
        chk(pads[2].level, 16'h0000);
        rd(8'h02, v);
        $display("test open drain done");
        // alternate output on group 0, direction still output
        v = 16'($random(seed));
        a = 16'($random(seed));
        wr(8'h00, v);
        // direction of group 0 is already output before the alternate is enabled
        alt[0].enable <= '1;
        alt[0].data   <= a;
        settle();
        chk(pins[0], v & a);
        @(posedge clock_in);
        alt[0].pwm_bypass <= '1;
        settle();
        chk(pins[0], a);
        // software keeps the latch at one, so gated alternate data passes unchanged
        @(posedge clock_in);
        alt[0].pwm_bypass <= '0;
        wr(8'h00, 16'hffff);
        settle();
        chk(pins[0], a);
        @(posedge clock_in);
        alt[0].pwm_bypass <= '1;
        wr(8'h10, 16'h0);
        settle();
        chk(pins[0], ext[0]);
        @(posedge clock_in);
        alt[0].auto_dir_en <= '1;
        alt[0].auto_dir    <= '1;
        settle();
        chk(pins[0], a);
        @(posedge clock_in);
        alt[0].auto_dir <= '0;
        settle();
        chk(pins[0], ext[0]);
        @(posedge clock_in);
        alt[0] <= '0;
        ext[5] <= 16'($random(seed));
        wr(8'h11, 16'hffff);
        wr(8'h01, v);
        rd(8'h01, v);
        rd(8'h05, ext[5]);
        $display("test alternate done");
        // reset again in mid-run, raised just after a rising edge
        @(posedge clock_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        rst_in <= 1'b0;
        rd(8'h11, 16'h0);
        $display("test second reset done");
        complete_run();
    end
endmodule
